//--- rtl/csc_pkg.sv
/*
 * Package for the CPU system control block: SPECIAL_FUNCTION_SPACE addresses, field
 * positions, reset values, cycle counts and the shared bus structs.
 * Assumes a single 100 MHz oscillator clock domain.
 */
package csc_pkg;

    // ========================================================
    // Special-function addresses
    // ========================================================
    localparam logic [7:0] AUX_STROBE_ADDR = 8'h8e;
    localparam logic [7:0] PTR_SELECT_ADDR = 8'ha2;
    localparam logic [7:0] DPL_ADDR = 8'h82;
    localparam logic [7:0] DPH_ADDR = 8'h83;
    localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
    localparam logic [7:0] CLK_CTRL_ADDR = 8'h8f;

    // ========================================================
    // Field positions, reset values and select write mask
    // ========================================================
    localparam int STROBE_OFF_BIT = 0;
    localparam int PTR_SEL_BIT = 0;
    localparam int HARD_ZERO_BIT = 2;
    localparam int GEN_FLAG_BIT = 3;
    localparam int POWER_ON_BIT = 4;
    localparam int DBL_SPEED_BIT = 0;
    localparam logic [7:0] AUX_STROBE_RST = 8'h00;
    localparam logic [7:0] PTR_SELECT_RST = 8'h00;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [7:0] PTR_SELECT_WMASK = 8'hfb;

    // ========================================================
    // Memory map
    // ========================================================
    localparam logic [7:0] LOW_DATA_TOP = 8'h7f;
    localparam logic [15:0] ONCHIP_CODE_TOP = 16'h1fff;

    // ========================================================
    // Machine cycle lengths in oscillator clocks; reset wait in machine cycles
    // ========================================================
    localparam logic [3:0] CYCLE_SLOW = 4'hc;
    localparam logic [3:0] CYCLE_FAST = 4'h6;
    localparam logic [3:0] RESET_CYCLES = 4'h2;

    // CPU-side SPECIAL_FUNCTION_SPACE access
    typedef struct packed {
        logic wr;
        logic rd;
        logic direct;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csc_sfr_req_t;

    // Data pointer operations from the CPU core
    typedef struct packed {
        logic inc;
        logic load;
        logic [15:0] value;
    } csc_dptr_op_t;

endpackage : csc_pkg

//--- rtl/csc_cycle_gen.sv
/*
 * Machine cycle timer: counts oscillator clocks and pulses at the end
 * of each machine cycle, 6 or 12 clocks long.
 * Assumes the mode input is stable, changing only between cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module csc_cycle_gen (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic fast_i,
    output logic cycle_end_o,
    output logic [3:0] phase_o
);

    logic [3:0] count_ff;
    logic [3:0] nxt_count;
    logic [3:0] cycle_len;
    logic last_clk;

    // ========================================================
    // Length select
    // ========================================================
    assign cycle_len = fast_i ? csc_pkg::CYCLE_FAST : csc_pkg::CYCLE_SLOW;
    // A shortened cycle ends at once if the count is already past it
    assign last_clk = (count_ff >= cycle_len - 4'h1);
    assign nxt_count = last_clk ? 4'h0 : count_ff + 4'h1;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_ff <= 4'h0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign cycle_end_o = last_clk;
    assign phase_o = count_ff;

endmodule : csc_cycle_gen
`default_nettype wire

//--- rtl/csc_sys_ctrl.sv
/*
 * CPU system control: clock mode, address latch strobe, dual data
 * pointers, memory space decode and reset sequencing.
 * Assumes the CPU core drives SPECIAL_FUNCTION_SPACE accesses and instruction class flags
 * synchronous to clk_i, and that on-chip RAM itself has no reset.
 */
// Summary of operation
// - Twelve-clock machine cycle when both double-speed bits are off.
// - Nonvolatile bit forces six clocks; otherwise register bit selects.
// - Strobe-off clear: strobe toggles every clock, pulsing at half oscillator rate.
// - Strobe-off set: strobe only during external or code-space moves.
// - Two 16-bit data pointers; operations use the selected one.
// - Select bit 0 picks first pointer, 1 picks second.
// - Bit 2 of select register reads zero and ignores writes.
// - Bit 3 of select register is a plain software flag.
// - Strobe control and select registers reset to zero.
// - Power-on flag set at power-up, held until software clears.
// - After reset fetch at 0000H, or enter programming mode.
// - System reset while running leaves on-chip RAM untouched.
// - Reset sequence weakly pulls every port pin high.
// - Low 128 bytes reachable directly and indirectly.
// - Full 256 bytes reachable indirectly; upper half indirect only.
// - Special registers answer direct access only; indirect reaches RAM.
// - 64 kB code space decoded, 8 kB on chip.
`timescale 1ns/10ps
`default_nettype none
module csc_sys_ctrl (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_up_i,
    input wire logic nonvolatile_double_speed_i,
    input wire logic isp_entry_i,
    input wire csc_pkg::csc_sfr_req_t sfr_req_i,
    input wire csc_pkg::csc_dptr_op_t dptr_op_i,
    input wire logic external_data_move_i,
    input wire logic code_space_move_i,
    input wire logic [15:0] code_addr_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    output logic ram_sel_o,
    output logic [15:0] dptr_o,
    output logic addr_strobe_o,
    output logic fast_mode_o,
    output logic cycle_end_o,
    output logic core_reset_o,
    output logic [15:0] fetch_start_o,
    output logic in_system_programming_o,
    output logic port_pullup_o,
    output logic code_onchip_o,
    output logic code_external_o,
    output logic power_on_flag_o
);

    typedef enum logic [1:0] {
        CSC_HOLD,
        CSC_WAIT,
        CSC_RUN,
        CSC_PROG
    } csc_state_t;

    logic [7:0] auxiliary_strobe_control_ff;
    logic [7:0] pointer_select_control_ff;
    logic register_double_speed_ff;
    logic power_on_flag_ff;
    csc_state_t state_ff;
    csc_state_t nxt_state;
    logic [3:0] rst_cnt_ff;
    logic [3:0] nxt_rst_cnt;
    logic strobe_ff;
    logic [7:0] rdata_ff;
    logic hit_ff;
    logic ram_sel_ff;
    logic [15:0] dptr_ff;
    logic fast_ff;
    logic core_reset_ff;
    logic [15:0] fetch_ff;
    logic prog_ff;
    logic pullup_ff;
    logic onchip_ff;
    logic ext_ff;
    logic cycle_end_ff;
    logic pending_pup_ff;

    logic fast_mode;
    logic cyc_end;
    logic pointer_select;
    logic strobe_off;
    logic move_active;
    logic nxt_strobe;
    logic sfr_dir_wr;
    logic sfr_dir_rd;
    logic [7:0] sfr_rd_mux;
    logic is_sfr;
    logic nxt_pof;
    logic [15:0] sel_ptr;

    // ========================================================
    // Address decode
    // ========================================================
    function automatic logic sfr_match(input logic [7:0] a, input logic [7:0] b);
        sfr_match = (a == b);
    endfunction : sfr_match

    assign is_sfr = sfr_req_i.direct && sfr_req_i.addr > csc_pkg::LOW_DATA_TOP;
    assign sfr_dir_wr = sfr_req_i.wr && is_sfr;
    assign sfr_dir_rd = sfr_req_i.rd && is_sfr;

    // ========================================================
    // Clock mode
    // ========================================================
    // twelve-clock default
    assign fast_mode = nonvolatile_double_speed_i | register_double_speed_ff;

    csc_cycle_gen u_cycle (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .fast_i(fast_mode),
        .cycle_end_o(cyc_end),
        .phase_o()
    );

    // ========================================================
    // Register writes
    // ========================================================
    assign pointer_select = pointer_select_control_ff[csc_pkg::PTR_SEL_BIT];
    assign strobe_off = auxiliary_strobe_control_ff[csc_pkg::STROBE_OFF_BIT];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            auxiliary_strobe_control_ff <= csc_pkg::AUX_STROBE_RST;
            pointer_select_control_ff <= csc_pkg::PTR_SELECT_RST;
            register_double_speed_ff <= 1'b0;
        end else begin
            if (sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::AUX_STROBE_ADDR)) begin
                auxiliary_strobe_control_ff <= sfr_req_i.wdata;
            end
            if (sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::PTR_SELECT_ADDR)) begin
                pointer_select_control_ff <= sfr_req_i.wdata & csc_pkg::PTR_SELECT_WMASK;
            end
            if (sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::CLK_CTRL_ADDR)) begin
                register_double_speed_ff <= sfr_req_i.wdata[csc_pkg::DBL_SPEED_BIT];
            end
        end
    end

    // ========================================================
    // Power-on flag
    // ========================================================
    // Power-up sets it, outranking a software clear in the same cycle.
    // sticky until cleared
    assign nxt_pof = (power_up_i || pending_pup_ff) ? 1'b1 :
        (sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::PWR_CTRL_ADDR)) ?
        sfr_req_i.wdata[csc_pkg::POWER_ON_BIT] & power_on_flag_ff : power_on_flag_ff;

    // Flag is outside pin reset: power_up_i seen during reset is held pending
    always_ff @(posedge clk_i) begin
        power_on_flag_ff <= nxt_pof;
        pending_pup_ff <= power_up_i || (pending_pup_ff && sys_rst_i);
    end

    // ========================================================
    // Data pointers
    // ========================================================
    // two pointers
    generate
        for (genvar gi = 0; gi < 2; gi++) begin : g_dptr
            logic [15:0] ptr_ff;
            logic hit_lo;
            logic hit_hi;
            logic mine;
            assign mine = (pointer_select == 1'(gi));
            assign hit_lo = mine && sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::DPL_ADDR);
            assign hit_hi = mine && sfr_dir_wr && sfr_match(sfr_req_i.addr, csc_pkg::DPH_ADDR);
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    ptr_ff <= 16'h0000;
                end else if (mine && dptr_op_i.load) begin
                    ptr_ff <= dptr_op_i.value;
                end else if (mine && dptr_op_i.inc) begin
                    ptr_ff <= ptr_ff + 16'h0001;
                end else if (hit_lo) begin
                    ptr_ff[7:0] <= sfr_req_i.wdata;
                end else if (hit_hi) begin
                    ptr_ff[15:8] <= sfr_req_i.wdata;
                end
            end
        end
    endgenerate

    assign sel_ptr = pointer_select ? g_dptr[1].ptr_ff : g_dptr[0].ptr_ff;

    // ========================================================
    // Read mux
    // ========================================================
    assign sfr_rd_mux =
        sfr_match(sfr_req_i.addr, csc_pkg::AUX_STROBE_ADDR) ? auxiliary_strobe_control_ff :
        sfr_match(sfr_req_i.addr, csc_pkg::PTR_SELECT_ADDR) ? pointer_select_control_ff :
        sfr_match(sfr_req_i.addr, csc_pkg::DPL_ADDR) ? sel_ptr[7:0] :
        sfr_match(sfr_req_i.addr, csc_pkg::DPH_ADDR) ? sel_ptr[15:8] :
        sfr_match(sfr_req_i.addr, csc_pkg::CLK_CTRL_ADDR) ? {7'h00, register_double_speed_ff} :
        sfr_match(sfr_req_i.addr, csc_pkg::PWR_CTRL_ADDR) ?
            (8'h01 << csc_pkg::POWER_ON_BIT) & {8{power_on_flag_ff}} : 8'h00;

    // ========================================================
    // Address latch strobe
    // ========================================================
    assign move_active = external_data_move_i | code_space_move_i;
    assign nxt_strobe = (!strobe_off || move_active) ? ~strobe_ff : 1'b0;

    // ========================================================
    // Reset sequencer
    // ========================================================
    // Counts two machine cycles after the pin releases before the core runs
    // two cycles wait
    always_comb begin
        nxt_state = state_ff;
        nxt_rst_cnt = rst_cnt_ff;
        case (state_ff)
            CSC_HOLD: begin
                nxt_state = CSC_WAIT;
                nxt_rst_cnt = 4'h0;
            end
            CSC_WAIT: begin
                if (cyc_end) begin
                    nxt_rst_cnt = rst_cnt_ff + 4'h1;
                end
                if (cyc_end && rst_cnt_ff == csc_pkg::RESET_CYCLES - 4'h1) begin
                    nxt_state = isp_entry_i ? CSC_PROG : CSC_RUN;
                end
            end
            CSC_RUN: nxt_state = CSC_RUN;
            CSC_PROG: nxt_state = CSC_PROG;
            default: nxt_state = CSC_HOLD;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_ff <= CSC_HOLD;
            rst_cnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            rst_cnt_ff <= nxt_rst_cnt;
        end
    end

    // ========================================================
    // Registered outputs
    // ========================================================
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            strobe_ff <= 1'b0;
            rdata_ff <= 8'h00;
            hit_ff <= 1'b0;
            ram_sel_ff <= 1'b0;
            dptr_ff <= 16'h0000;
            fast_ff <= 1'b0;
            core_reset_ff <= 1'b1;
            fetch_ff <= csc_pkg::RESET_VECTOR;
            prog_ff <= 1'b0;
            pullup_ff <= 1'b1;
            onchip_ff <= 1'b0;
            ext_ff <= 1'b0;
            cycle_end_ff <= 1'b0;
        end else begin
            strobe_ff <= nxt_strobe;
            rdata_ff <= sfr_dir_rd ? sfr_rd_mux : 8'h00;
            hit_ff <= (sfr_req_i.rd | sfr_req_i.wr) & is_sfr;
            ram_sel_ff <= (sfr_req_i.rd | sfr_req_i.wr) & ~is_sfr;
            dptr_ff <= sel_ptr;
            fast_ff <= fast_mode;
            core_reset_ff <= (nxt_state != CSC_RUN);
            fetch_ff <= csc_pkg::RESET_VECTOR;
            prog_ff <= (nxt_state == CSC_PROG);
            pullup_ff <= (nxt_state == CSC_HOLD) || (nxt_state == CSC_WAIT);
            onchip_ff <= code_addr_i <= csc_pkg::ONCHIP_CODE_TOP;
            ext_ff <= code_addr_i > csc_pkg::ONCHIP_CODE_TOP;
            cycle_end_ff <= cyc_end;
        end
    end

    assign sfr_rdata_o = rdata_ff;
    assign sfr_hit_o = hit_ff;
    assign ram_sel_o = ram_sel_ff;
    assign dptr_o = dptr_ff;
    assign addr_strobe_o = strobe_ff;
    assign fast_mode_o = fast_ff;
    assign cycle_end_o = cycle_end_ff;
    assign core_reset_o = core_reset_ff;
    assign fetch_start_o = fetch_ff;
    assign in_system_programming_o = prog_ff;
    assign port_pullup_o = pullup_ff;
    assign code_onchip_o = onchip_ff;
    assign code_external_o = ext_ff;
    assign power_on_flag_o = power_on_flag_ff;

endmodule : csc_sys_ctrl
`default_nettype wire

//--- tb/csc_sys_ctrl_props.sv
/*
 * Port checker for csc_sys_ctrl.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module csc_sys_ctrl_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic power_up_i,
    input wire logic nonvolatile_double_speed_i,
    input wire csc_pkg::csc_sfr_req_t sfr_req_i,
    input wire logic external_data_move_i,
    input wire logic code_space_move_i,
    input wire logic [15:0] code_addr_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic sfr_hit_o,
    input wire logic ram_sel_o,
    input wire logic addr_strobe_o,
    input wire logic fast_mode_o,
    input wire logic core_reset_o,
    input wire logic in_system_programming_o,
    input wire logic [15:0] fetch_start_o,
    input wire logic port_pullup_o,
    input wire logic code_onchip_o,
    input wire logic code_external_o,
    input wire logic power_on_flag_o
);
    // ========================================================
    // Shadow state
    // ========================================================
    logic [5:0] age_ff;
    logic off_ff;
    logic dbl_ff;
    wire acc = sfr_req_i.rd | sfr_req_i.wr;
    wire wr_dir = sfr_req_i.wr & sfr_req_i.direct;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            age_ff <= 6'h00;
            off_ff <= 1'b0;
            dbl_ff <= 1'b0;
        end else begin
            // Saturates so the reset-window checks stay quiet in long runs
            if (age_ff != 6'h3f)
                age_ff <= age_ff + 6'h01;
            if (wr_dir && sfr_req_i.addr == 8'h8e)
                off_ff <= sfr_req_i.wdata[0];
            if (wr_dir && sfr_req_i.addr == 8'h8f)
                dbl_ff <= sfr_req_i.wdata[0];
        end
    end

    // ========================================================
    // Properties
    // ========================================================
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_direct_sfr;
        acc && sfr_req_i.direct && sfr_req_i.addr >= 8'h80;
    endsequence
    sequence s_ram_access;
        acc && (!sfr_req_i.direct || sfr_req_i.addr <= 8'h7f);
    endsequence
    AST_FETCH_VECTOR: assert property (fetch_start_o == 16'h0000)
        else $error("fetch start not zero");
    AST_SFR_DIRECT: assert property (s_direct_sfr |=> sfr_hit_o && !ram_sel_o)
        else $error("direct access not routed to registers");
    AST_RAM_ROUTE: assert property (s_ram_access |=> ram_sel_o && !sfr_hit_o)
        else $error("access not routed to data memory");
    AST_PTR_ZERO: assert property (sfr_req_i.rd && sfr_req_i.direct &&
        sfr_req_i.addr == 8'ha2 |=> sfr_hit_o && !sfr_rdata_o[2])
        else $error("select register bit two not zero");
    AST_FAST_FORCED: assert property (nonvolatile_double_speed_i |=> fast_mode_o)
        else $error("six-clock mode not forced");
    AST_SLOW_DEFAULT: assert property (!nonvolatile_double_speed_i && !dbl_ff |=> !fast_mode_o)
        else $error("twelve-clock mode not kept");
    AST_STROBE_RUN: assert property (age_ff > 6'd4 && !$past(core_reset_o, 3) &&
        !$past(off_ff) && !$past(off_ff, 2) |-> addr_strobe_o != $past(addr_strobe_o))
        else $error("strobe not toggling");
    AST_STROBE_QUIET: assert property ($past(off_ff) && !$past(external_data_move_i) &&
        !$past(code_space_move_i) |-> !addr_strobe_o)
        else $error("strobe active with no move");
    AST_CODE_SPLIT: assert property (age_ff > 6'd1 |->
        code_onchip_o == ($past(code_addr_i) <= 16'h1fff) && code_external_o != code_onchip_o)
        else $error("code space decode wrong");
    AST_RESET_WAIT: assert property (age_ff < 6'd10 |-> core_reset_o && port_pullup_o)
        else $error("reset wait ended early");
    AST_WAIT_BOUND: assert property (age_ff == 6'd40 |-> core_reset_o == in_system_programming_o)
        else $error("core still held in reset");
    AST_POF_SET: assert property (power_up_i |=> power_on_flag_o)
        else $error("power-on flag not set");
endmodule : csc_sys_ctrl_props
`default_nettype wire

//--- tb/csc_ext_mem.sv
/*
 * External memory model: counts each strobe rise as an address latch event.
 * Assumes the strobe changes only on the oscillator clock.
 */
`timescale 1ns/10ps
`default_nettype none
module csc_ext_mem (
    input wire logic clk_i,
    input wire logic strobe_i,
    input wire logic clear_i,
    output logic [15:0] latch_count_o
);
    logic strobe_ff;
    // Count latch events; clear gives the bench a clean window
    always_ff @(posedge clk_i) begin
        strobe_ff <= strobe_i;
        if (clear_i)
            latch_count_o <= 16'h0000;
        else if (strobe_i && !strobe_ff)
            latch_count_o <= latch_count_o + 16'h0001;
    end
endmodule : csc_ext_mem
`default_nettype wire

//--- tb/csc_sys_ctrl_test.sv
/*
 * Self-checking bench for csc_sys_ctrl with the external memory model.
 * Assumes the package, design, checker and model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module csc_sys_ctrl_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic power_up_i = 1'b1;
    logic nonvolatile_double_speed_i = 1'b0;
    logic isp_entry_i = 1'b0;
    csc_pkg::csc_sfr_req_t sfr_req_i = '0;
    csc_pkg::csc_dptr_op_t dptr_op_i = '0;
    logic external_data_move_i = 1'b0;
    logic code_space_move_i = 1'b0;
    logic [15:0] code_addr_i = 16'h0000;
    logic clr = 1'b0;
    logic [7:0] sfr_rdata_o;
    logic sfr_hit_o, ram_sel_o, addr_strobe_o, fast_mode_o, cycle_end_o, core_reset_o;
    logic in_system_programming_o, port_pullup_o, code_onchip_o, code_external_o;
    logic power_on_flag_o;
    logic [15:0] dptr_o, fetch_start_o, pulses;
    int n_errors = 0;
    int checks = 0;
    integer seed = 20;
    logic [7:0] exp_q[$];
    logic rd_q1 = 1'b0;

    csc_sys_ctrl dut_u (.clk_i, .sys_rst_i, .power_up_i, .nonvolatile_double_speed_i,
        .isp_entry_i, .sfr_req_i, .dptr_op_i, .external_data_move_i, .code_space_move_i,
        .code_addr_i, .sfr_rdata_o, .sfr_hit_o, .ram_sel_o, .dptr_o, .addr_strobe_o,
        .fast_mode_o, .cycle_end_o, .core_reset_o, .fetch_start_o, .in_system_programming_o,
        .port_pullup_o, .code_onchip_o, .code_external_o, .power_on_flag_o);
    csc_ext_mem mem_u (.clk_i, .strobe_i(addr_strobe_o), .clear_i(clr), .latch_count_o(pulses));

    initial forever #5 clk_i = ~clk_i;
    always @(negedge clk_i) code_addr_i <= code_addr_i + 16'h0731;

    // ========================================================
    // Checking
    // ========================================================
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Read data lands one edge after the taking edge
    always @(posedge clk_i) begin
        rd_q1 <= sfr_req_i.rd;
    end
    always @(negedge clk_i) begin
        if (rd_q1 && exp_q.size() > 0) begin
            cmp({8'h00, sfr_rdata_o}, {8'h00, exp_q.pop_front()});
        end
    end

    // ========================================================
    // Drivers
    // ========================================================
    task automatic wait_run;
        for (int i = 0; i < 100 && core_reset_o !== 1'b0 &&
             in_system_programming_o !== 1'b1; i++) @(negedge clk_i);
        // Programming entry keeps the core held, so either exit ends the wait
        cmp({14'h0000, core_reset_o, in_system_programming_o}, {14'h0000, {2{isp_entry_i}}});
        if (core_reset_o !== 1'b0 && in_system_programming_o !== 1'b1) report_and_stop;
    endtask : wait_run

    task automatic do_reset;
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        cmp({15'h0000, port_pullup_o}, 16'h0001);
        sys_rst_i = 1'b0;
        wait_run;
    endtask : do_reset

    task automatic special_function_space(input logic w, input logic [7:0] a, input logic [7:0] v,
                       input logic [7:0] e, input logic d = 1'b1);
        @(negedge clk_i);
        sfr_req_i = '{wr: w, rd: !w, direct: d, addr: a, wdata: v};
        if (!w) exp_q.push_back(e);
        @(negedge clk_i);
        sfr_req_i = '0;
    endtask : special_function_space

    task automatic dop(input logic i, input logic l, input logic [15:0] v);
        @(negedge clk_i);
        dptr_op_i = '{inc: i, load: l, value: v};
        @(negedge clk_i);
        dptr_op_i = '0;
        repeat (2) @(negedge clk_i);
    endtask : dop

    task automatic cyc_len(input logic [15:0] e);
        logic [15:0] n;
        for (int i = 0; i < 40 && cycle_end_o !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);
        n = 16'h0001;
        while (n < 16'h0028 && cycle_end_o !== 1'b1) begin
            @(negedge clk_i);
            n++;
        end
        cmp(n, e);
    endtask : cyc_len

    task automatic strobes(input logic x, input logic c, input logic [15:0] e);
        @(negedge clk_i);
        external_data_move_i = x;
        code_space_move_i = c;
        clr = 1'b1;
        @(negedge clk_i);
        clr = 1'b0;
        repeat (20) @(negedge clk_i);
        cmp(pulses, e);
        external_data_move_i = 1'b0;
        code_space_move_i = 1'b0;
    endtask : strobes

    // ========================================================
    // Scenarios
    // ========================================================
    initial begin
        logic [15:0] v;
        logic [7:0] a;
        do_reset;
        power_up_i = 1'b0;
        cmp({15'h0000, in_system_programming_o}, 16'h0000);
        cmp({15'h0000, power_on_flag_o}, 16'h0001);
        special_function_space(1'b0, csc_pkg::AUX_STROBE_ADDR, 8'h00, 8'h00);
        special_function_space(1'b0, csc_pkg::PTR_SELECT_ADDR, 8'h00, 8'h00);
        special_function_space(1'b1, csc_pkg::PTR_SELECT_ADDR, 8'hff, 8'h00);
        special_function_space(1'b0, csc_pkg::PTR_SELECT_ADDR, 8'h00, 8'hfb);
        special_function_space(1'b1, csc_pkg::PTR_SELECT_ADDR, 8'h08, 8'h00);
        special_function_space(1'b0, csc_pkg::PTR_SELECT_ADDR, 8'h00, 8'h08);
        dop(1'b0, 1'b1, 16'h1234);
        special_function_space(1'b1, csc_pkg::PTR_SELECT_ADDR, 8'h01, 8'h00);
        v = 16'($random(seed));
        dop(1'b0, 1'b1, v);
        dop(1'b1, 1'b0, 16'h0000);
        v = v + 16'h0001;
        cmp(dptr_o, v);
        special_function_space(1'b0, csc_pkg::DPL_ADDR, 8'h00, v[7:0]);
        special_function_space(1'b0, csc_pkg::DPH_ADDR, 8'h00, v[15:8]);
        special_function_space(1'b1, csc_pkg::PTR_SELECT_ADDR, 8'h00, 8'h00);
        repeat (2) @(negedge clk_i);
        cmp(dptr_o, 16'h1234);
        special_function_space(1'b1, csc_pkg::DPH_ADDR, 8'h56, 8'h00);
        @(negedge clk_i);
        cmp(dptr_o, 16'h5634);
        for (int m = 0; m < 4; m++) begin
            nonvolatile_double_speed_i = m[1];
            special_function_space(1'b1, csc_pkg::CLK_CTRL_ADDR, {7'h00, m[0]}, 8'h00);
            repeat (2) @(negedge clk_i);
            cmp({15'h0000, fast_mode_o}, {15'h0000, m[1] | m[0]});
            cyc_len((m != 0) ? 16'h0006 : 16'h000c);
        end
        strobes(1'b0, 1'b0, 16'h000a);
        special_function_space(1'b1, csc_pkg::AUX_STROBE_ADDR, 8'h01, 8'h00);
        special_function_space(1'b0, csc_pkg::AUX_STROBE_ADDR, 8'h00, 8'h01);
        strobes(1'b0, 1'b0, 16'h0000);
        strobes(1'b1, 1'b0, 16'h000a);
        strobes(1'b0, 1'b1, 16'h000a);
        special_function_space(1'b1, 8'hc5, 8'h55, 8'h00);
        special_function_space(1'b0, 8'hc5, 8'h00, 8'h00);
        for (int k = 0; k < 16; k++) begin
            a = 8'($random(seed));
            special_function_space(1'b0, a, 8'h00, 8'h00, 1'b0);
            special_function_space(1'b0, {1'b0, a[6:0]}, 8'h00, 8'h00);
        end
        special_function_space(1'b1, csc_pkg::PWR_CTRL_ADDR, 8'h10, 8'h00);
        cmp({15'h0000, power_on_flag_o}, 16'h0001);
        special_function_space(1'b1, csc_pkg::PWR_CTRL_ADDR, 8'h00, 8'h00);
        cmp({15'h0000, power_on_flag_o}, 16'h0000);
        isp_entry_i = 1'b1;
        do_reset;
        cmp({15'h0000, power_on_flag_o}, 16'h0000);
        cmp({15'h0000, in_system_programming_o}, 16'h0001);
        cmp(fetch_start_o, 16'h0000);
        isp_entry_i = 1'b0;
        do_reset;
        cmp({15'h0000, in_system_programming_o}, 16'h0000);
        report_and_stop;
    end
endmodule : csc_sys_ctrl_test

bind csc_sys_ctrl csc_sys_ctrl_props props_u (.clk_i, .sys_rst_i, .power_up_i,
    .nonvolatile_double_speed_i, .sfr_req_i, .external_data_move_i, .code_space_move_i,
    .code_addr_i, .sfr_rdata_o, .sfr_hit_o, .ram_sel_o, .addr_strobe_o, .fast_mode_o,
    .core_reset_o, .in_system_programming_o, .fetch_start_o, .port_pullup_o, .code_onchip_o,
    .code_external_o,
    .power_on_flag_o);
`default_nettype wire
